// >>> irrx_pkg.sv
// constants, types and register map of the ir receiver error and noise filter
// assumes a single 200 MHz clock domain and an apb master for software access
package irrx_pkg;

   // =====================================================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CMP0   = 8'h04;
   localparam logic [7:0] ADDR_SHIFT  = 8'h28;
   localparam logic [7:0] ADDR_BITCNT = 8'h2C;
   localparam logic [7:0] ADDR_DATA   = 8'h30;
   localparam logic [7:0] ADDR_STATUS = 8'h34;
   localparam logic [7:0] ADDR_CLEAR  = 8'h38;
   localparam logic [7:0] ADDR_IEN    = 8'h3C;

   // =====================================================================
   // control fields
   localparam int unsigned CTRL_EN_BIT    = 0;
   localparam int unsigned CTRL_HALVE_BIT = 5;
   localparam int unsigned CTRL_WIDTH_BIT = 6;

   // =====================================================================
   // compare register indices
   localparam int unsigned CMP_GPH_MIN = 0;
   localparam int unsigned CMP_GPH_MAX = 1;
   localparam int unsigned CMP_DL_MIN  = 2;
   localparam int unsigned CMP_DL_MAX  = 3;
   localparam int unsigned CMP_ZH_MIN  = 4;
   localparam int unsigned CMP_ZH_MAX  = 5;
   localparam int unsigned CMP_OH_MIN  = 6;
   localparam int unsigned CMP_OH_MAX  = 7;
   localparam int unsigned CMP_END     = 8;
   localparam int unsigned NUM_CMP     = 9;

   // =====================================================================
   // event bits of status, clear and enable
   localparam int unsigned EV_ERR   = 0;
   localparam int unsigned EV_GUIDE = 1;
   localparam int unsigned EV_FULL  = 2;
   localparam int unsigned EV_END   = 3;
   localparam int unsigned NUM_EV   = 4;

   // =====================================================================
   // widths and reset values
   localparam int unsigned CW         = 8;
   localparam logic [7:0]  CMP_RST    = 8'h00;
   localparam logic [7:0]  CNT_MAX    = 8'hFF;
   localparam logic [3:0]  BITS_FULL  = 4'h7;

   typedef enum logic [2:0] {
      IRRX_IDLE  = 3'b000,
      IRRX_GUIDE = 3'b001,
      IRRX_LOW   = 3'b011,
      IRRX_HIGH  = 3'b010,
      IRRX_ENDW  = 3'b110,
      IRRX_HALT  = 3'b111
   } irrx_state_t;

   typedef struct packed {
      logic width_sel;
      logic halve_sel;
      logic enable;
   } irrx_ctrl_t;

endpackage

// >>> irrx_noise_filter.sv
// operation clock divider, op-clock synchroniser and sampling noise filter
// assumes pin_level is already synchronised to mclk by two flip-flops
`timescale 1ns/1ps
module irrx_noise_filter (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // configuration
   input  wire logic clock_halve_sel,
   input  wire logic filter_width_sel,
   // input and result
   input  wire logic pin_level,
   output logic      op_tick,
   output logic      filt
);

   logic half_phase;
   logic op_sync;
   logic first_sample;
   logic second_sample;
   logic third_sample;

   // =====================================================================
   // operation clock
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         half_phase <= 1'b0;
      end else begin
         half_phase <= ~half_phase;
      end
   end

   assign op_tick = ~clock_halve_sel | half_phase;

   // =====================================================================
   // sample chain
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         op_sync       <= 1'b0;
         first_sample  <= 1'b0;
         second_sample <= 1'b0;
         third_sample  <= 1'b0;
      end else if (op_tick) begin
         op_sync      <= pin_level;
         first_sample <= op_sync;
         if (op_sync && first_sample) begin
            second_sample <= first_sample;
         end else begin
            second_sample <= op_sync;
         end
         if (op_sync == second_sample) begin
            third_sample <= second_sample;
         end
      end
   end

   assign filt = filter_width_sel ? third_sample : second_sample;

   // =====================================================================
   // checks
   sequence s_tick_now;
      op_tick;
   endsequence

   sequence s_tick_skip;
      !op_tick;
   endsequence

   halved_rate_a : assert property (@(posedge mclk) disable iff (rst)
      clock_halve_sel && op_tick ##1 clock_halve_sel |-> s_tick_skip ##1 s_tick_now)
      else $error("halved operation clock does not alternate");

   full_rate_a : assert property (@(posedge mclk) disable iff (rst)
      !clock_halve_sel |-> op_tick)
      else $error("operation clock missing at full rate");

   first_stage_a : assert property (@(posedge mclk) disable iff (rst)
      op_tick |=> first_sample == $past(op_sync))
      else $error("first sample is not the synchronised input delayed");

   second_agree_a : assert property (@(posedge mclk) disable iff (rst)
      op_tick |=> second_sample == $past(op_sync))
      else $error("second sample does not follow the synchronised input");

endmodule

// >>> irrx_receiver.sv
// ir receiver error detection and noise filter with apb register access
// assumes apb master on mclk; ir_input is asynchronous to mclk
`timescale 1ns/1ps
module irrx_receiver (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // remote control pin
   input  wire logic        ir_input,
   // interrupts
   output logic             irq,
   output logic             rx_error_irq
);

   irrx_pkg::irrx_ctrl_t             ctrl;
   irrx_pkg::irrx_state_t            state;
   irrx_pkg::irrx_state_t            next_state;
   logic [irrx_pkg::CW-1:0]          cmp [irrx_pkg::NUM_CMP];
   logic [irrx_pkg::CW-1:0]          cnt;
   logic [irrx_pkg::CW-1:0]          end_cnt;
   logic [7:0]                       rx_shift_reg;
   logic [3:0]                       rx_bit_count_reg;
   logic [7:0]                       rx_data;
   logic [irrx_pkg::NUM_EV-1:0]      status;
   logic [irrx_pkg::NUM_EV-1:0]      ien;
   logic [irrx_pkg::NUM_EV-1:0]      events;
   logic                             pin_meta;
   logic                             pin_sync;
   logic                             op_tick;
   logic                             filt;
   logic                             filt_q;
   logic                             rise;
   logic                             fall;
   logic                             err_armed;
   logic                             err_raw;
   logic                             err_evt;
   logic                             guide_evt;
   logic                             end_evt;
   logic                             bit_evt;
   logic                             bit_val;
   logic                             wr_acc;
   logic                             rd_acc;
   logic                             rd_shift;
   logic                             cmp_hit;
   logic [7:0]                       cmp_idx;

   // =====================================================================
   // pin synchroniser and noise filter
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= ir_input;
         pin_sync <= pin_meta;
      end
   end

   irrx_noise_filter u_filter (
      .mclk             (mclk),
      .rst              (rst),
      .clock_halve_sel  (ctrl.halve_sel),
      .filter_width_sel (ctrl.width_sel),
      .pin_level        (pin_sync),
      .op_tick          (op_tick),
      .filt             (filt)
   );

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         filt_q <= 1'b0;
      end else if (op_tick) begin
         filt_q <= filt;
      end
   end

   assign rise = op_tick & filt & ~filt_q;
   assign fall = op_tick & ~filt & filt_q;

   // =====================================================================
   // apb slave
   assign wr_acc   = psel & penable & pready & pwrite;
   assign rd_acc   = psel & penable & pready & ~pwrite;
   assign rd_shift = rd_acc & (paddr == irrx_pkg::ADDR_SHIFT);
   assign cmp_idx  = 8'((paddr - irrx_pkg::ADDR_CMP0) >> 2);
   assign cmp_hit  = (paddr[1:0] == 2'h0) && (paddr >= irrx_pkg::ADDR_CMP0)
                     && (cmp_idx < 8'(irrx_pkg::NUM_CMP));

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable & ~pready;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel & ~penable) begin
            unique case (paddr)
               irrx_pkg::ADDR_CTRL: begin
                  prdata[irrx_pkg::CTRL_EN_BIT]    <= ctrl.enable;
                  prdata[irrx_pkg::CTRL_HALVE_BIT] <= ctrl.halve_sel;
                  prdata[irrx_pkg::CTRL_WIDTH_BIT] <= ctrl.width_sel;
               end
               irrx_pkg::ADDR_SHIFT:  prdata[7:0] <= rx_shift_reg;
               irrx_pkg::ADDR_BITCNT: prdata[3:0] <= rx_bit_count_reg;
               irrx_pkg::ADDR_DATA:   prdata[7:0] <= rx_data;
               irrx_pkg::ADDR_STATUS: prdata[irrx_pkg::NUM_EV-1:0] <= status;
               irrx_pkg::ADDR_CLEAR:  prdata <= 32'h0000_0000;
               irrx_pkg::ADDR_IEN:    prdata[irrx_pkg::NUM_EV-1:0] <= ien;
               default: begin
                  if (cmp_hit) begin
                     prdata[irrx_pkg::CW-1:0] <= cmp[cmp_idx[3:0]];
                  end else begin
                     pslverr <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // =====================================================================
   // configuration registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl <= '0;
         ien  <= '0;
         for (int i = 0; i < irrx_pkg::NUM_CMP; i++) begin
            cmp[i] <= irrx_pkg::CMP_RST;
         end
      end else if (wr_acc) begin
         if (paddr == irrx_pkg::ADDR_CTRL) begin
            ctrl.enable    <= pwdata[irrx_pkg::CTRL_EN_BIT];
            ctrl.halve_sel <= pwdata[irrx_pkg::CTRL_HALVE_BIT];
            ctrl.width_sel <= pwdata[irrx_pkg::CTRL_WIDTH_BIT];
         end
         if (paddr == irrx_pkg::ADDR_IEN) begin
            ien <= pwdata[irrx_pkg::NUM_EV-1:0];
         end
         if (cmp_hit) begin
            cmp[cmp_idx[3:0]] <= pwdata[irrx_pkg::CW-1:0];
         end
      end
   end

   // =====================================================================
   // width counters
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
      end else if (op_tick) begin
         if (rise | fall) begin
            cnt <= '0;
         end else if (cnt != irrx_pkg::CNT_MAX) begin
            cnt <= cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         end_cnt <= '0;
      end else if (state != irrx_pkg::IRRX_ENDW) begin
         end_cnt <= '0;
      end else if (op_tick && end_cnt != irrx_pkg::CNT_MAX) begin
         end_cnt <= end_cnt + 8'h01;
      end
   end

   // =====================================================================
   // frame state machine
   always_comb begin
      next_state = state;
      err_raw    = 1'b0;
      guide_evt  = 1'b0;
      end_evt    = 1'b0;
      bit_evt    = 1'b0;
      bit_val    = 1'b0;
      if (!ctrl.enable) begin
         next_state = irrx_pkg::IRRX_IDLE;
      end else if (state == irrx_pkg::IRRX_HALT) begin
         if (rd_shift) begin
            next_state = irrx_pkg::IRRX_IDLE;
         end
      end else if (op_tick) begin
         unique case (state)
            irrx_pkg::IRRX_IDLE: begin
               if (rise) begin
                  next_state = irrx_pkg::IRRX_GUIDE;
               end
            end
            irrx_pkg::IRRX_GUIDE: begin
               if (fall) begin
                  if (cnt >= cmp[irrx_pkg::CMP_GPH_MIN] && cnt < cmp[irrx_pkg::CMP_GPH_MAX]) begin
                     guide_evt  = 1'b1;
                     next_state = irrx_pkg::IRRX_LOW;
                  end else begin
                     next_state = irrx_pkg::IRRX_IDLE;
                  end
               end
            end
            irrx_pkg::IRRX_LOW: begin
               if (rise) begin
                  if (cnt < cmp[irrx_pkg::CMP_DL_MIN]) begin
                     err_raw    = 1'b1;
                     next_state = irrx_pkg::IRRX_GUIDE;
                  end else begin
                     next_state = irrx_pkg::IRRX_HIGH;
                  end
               end else if (cnt >= cmp[irrx_pkg::CMP_DL_MAX]) begin
                  next_state = irrx_pkg::IRRX_ENDW;
               end
            end
            irrx_pkg::IRRX_HIGH: begin
               if (fall) begin
                  next_state = irrx_pkg::IRRX_LOW;
                  if (cnt < cmp[irrx_pkg::CMP_ZH_MIN]) begin
                     err_raw    = 1'b1;
                     next_state = irrx_pkg::IRRX_IDLE;
                  end else if (cnt < cmp[irrx_pkg::CMP_ZH_MAX]) begin
                     bit_evt = 1'b1;
                  end else if (cnt < cmp[irrx_pkg::CMP_OH_MIN]) begin
                     err_raw    = 1'b1;
                     next_state = irrx_pkg::IRRX_IDLE;
                  end else begin
                     bit_evt = 1'b1;
                     bit_val = 1'b1;
                  end
               end else if (cnt >= cmp[irrx_pkg::CMP_OH_MAX]) begin
                  err_raw    = 1'b1;
                  next_state = irrx_pkg::IRRX_IDLE;
               end
            end
            irrx_pkg::IRRX_ENDW: begin
               if (rise) begin
                  err_raw    = 1'b1;
                  next_state = irrx_pkg::IRRX_GUIDE;
               end else if (end_cnt >= cmp[irrx_pkg::CMP_END]) begin
                  end_evt    = 1'b1;
                  next_state = irrx_pkg::IRRX_HALT;
               end
            end
            irrx_pkg::IRRX_HALT: begin
            end
            default: begin
               next_state = irrx_pkg::IRRX_IDLE;
            end
         endcase
      end
   end

   assign err_evt = err_raw & err_armed;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= irrx_pkg::IRRX_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         err_armed <= 1'b0;
      end else if (!ctrl.enable || err_evt) begin
         err_armed <= 1'b0;
      end else if (guide_evt) begin
         err_armed <= 1'b1;
      end
   end

   // =====================================================================
   // shift, bit count and data registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_shift_reg     <= 8'h00;
         rx_bit_count_reg <= 4'h0;
         rx_data          <= 8'h00;
      end else if (!ctrl.enable || err_evt || rd_shift) begin
         rx_shift_reg     <= 8'h00;
         rx_bit_count_reg <= 4'h0;
      end else if (bit_evt) begin
         if (rx_bit_count_reg == irrx_pkg::BITS_FULL) begin
            rx_data          <= {bit_val, rx_shift_reg[7:1]};
            rx_shift_reg     <= 8'h00;
            rx_bit_count_reg <= 4'h0;
         end else begin
            rx_shift_reg     <= {bit_val, rx_shift_reg[7:1]};
            rx_bit_count_reg <= rx_bit_count_reg + 4'h1;
         end
      end
   end

   // =====================================================================
   // interrupt status, clear and enable
   assign events[irrx_pkg::EV_ERR]   = err_evt;
   assign events[irrx_pkg::EV_GUIDE] = guide_evt;
   assign events[irrx_pkg::EV_FULL]  = bit_evt && rx_bit_count_reg == irrx_pkg::BITS_FULL
                                       && ctrl.enable && !err_evt && !rd_shift;
   assign events[irrx_pkg::EV_END]   = end_evt;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         status <= '0;
      end else begin
         for (int i = 0; i < irrx_pkg::NUM_EV; i++) begin
            if (events[i]) begin
               status[i] <= 1'b1;
            end else if (wr_acc && paddr == irrx_pkg::ADDR_CLEAR && pwdata[i]) begin
               status[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq          <= 1'b0;
         rx_error_irq <= 1'b0;
      end else begin
         irq          <= |(status & ien);
         rx_error_irq <= err_evt;
      end
   end

   // =====================================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_low_short;
      state == irrx_pkg::IRRX_LOW && rise && cnt < cmp[irrx_pkg::CMP_DL_MIN] && err_armed
      && ctrl.enable;
   endsequence

   low_short_a : assert property (s_low_short |=> rx_error_irq)
      else $error("short data low did not raise error");

   end_short_a : assert property (state == irrx_pkg::IRRX_ENDW && rise && err_armed
      && ctrl.enable |=> rx_error_irq ##1 !rx_error_irq)
      else $error("short end width did not raise a single error");

   zero_short_a : assert property (state == irrx_pkg::IRRX_HIGH && fall && err_armed
      && ctrl.enable && cnt < cmp[irrx_pkg::CMP_ZH_MIN] |=> rx_error_irq)
      else $error("short high did not raise error");

   gap_high_a : assert property (state == irrx_pkg::IRRX_HIGH && fall && err_armed
      && ctrl.enable && cnt >= cmp[irrx_pkg::CMP_ZH_MAX] && cnt < cmp[irrx_pkg::CMP_OH_MIN]
      |=> rx_error_irq && state == irrx_pkg::IRRX_IDLE)
      else $error("high between bit windows did not raise error");

   long_high_a : assert property (state == irrx_pkg::IRRX_HIGH && op_tick && !fall
      && err_armed && ctrl.enable && cnt >= cmp[irrx_pkg::CMP_OH_MAX] |=> rx_error_irq)
      else $error("long high did not raise error at once");

   guide_gate_a : assert property ($rose(rx_error_irq) |-> $past(err_armed))
      else $error("error raised before a valid guide");

   single_error_a : assert property (rx_error_irq |-> !err_armed ##1
      (!rx_error_irq || $past(guide_evt, 2) || $past(err_armed)))
      else $error("second error without new guide");

   clear_shift_a : assert property (err_evt |=> rx_shift_reg == 8'h00
      && rx_bit_count_reg == 4'h0)
      else $error("error did not clear shift and bit count");

   end_start_a : assert property (end_cnt != 8'h00 |-> state == irrx_pkg::IRRX_ENDW
      || $past(state) == irrx_pkg::IRRX_ENDW)
      else $error("end count ran outside end width");

   restart_a : assert property (rise || fall |=> cnt == 8'h00)
      else $error("width counter did not restart at edge");

endmodule

// >>> irrx_ir_source.sv
// remote-control transmitter model driving the receiver pin
// assumes the bench calls send() from its own thread on mclk
`timescale 1ns/1ps
module irrx_ir_source (
   // clock
   input  wire logic mclk,
   // pin
   output logic      ir_out
);
   // =====================================================================
   // level generator, changes only after a rising edge
   initial ir_out = 1'b0;

   task automatic send(input logic lvl, input int cycles);
      @(posedge mclk);
      ir_out <= lvl;
      repeat (cycles - 1) @(posedge mclk);
   endtask
endmodule

// >>> irrx_receiver_tb.sv
// self-checking bench for the ir receiver error logic and noise filter
// assumes irrx_pkg is compiled first; apb master and pin model on mclk
`timescale 1ns/1ps
module irrx_receiver_tb;
   logic        mclk, rst, psel, penable, pwrite, ir_input;
   logic        pready, pslverr, irq, rx_error_irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        e;
   int          num_errors, checks_done, pulses, exp_err, m, s, i, lo, hi;
   int          seed = 32'h3471;
   int          cmp_val [9] = '{10, 40, 12, 30, 4, 8, 10, 60, 20};

   irrx_ir_source src (.mclk(mclk), .ir_out(ir_input));
   irrx_receiver uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ir_input(ir_input), .irq(irq),
      .rx_error_irq(rx_error_irq));

   // =====================================================================
   // clock, pulse counter, watchdog
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) if (rx_error_irq === 1'b1) pulses++;
   initial begin
      #100000;
      num_errors++;
      stop_test();
   end

   // =====================================================================
   // shared tasks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // =====================================================================
   // main sequence
   function automatic logic [31:0] exp_status(input int sc);
      return (sc == 5) ? 32'h0000000A : 32'h00000003;
   endfunction

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pulses = 0;
      exp_err = 0;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, irrx_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl reset", 32'h0, q);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      for (i = 0; i < 9; i++) apb(1'b1, irrx_pkg::ADDR_CMP0 + 8'(4 * i), 32'(cmp_val[i]));
      apb(1'b0, irrx_pkg::ADDR_CMP0 + 8'h08, 32'h0);
      chk("compare readback", 32'h0000000C, q);
      // per setting one error kind: short low, short high, gap high, long high,
      // short end width, then a clean frame end
      for (s = 0; s < 6; s++) begin
         m = s[1] ? 2 : 1;
         apb(1'b1, irrx_pkg::ADDR_CTRL, 32'h0);
         apb(1'b1, irrx_pkg::ADDR_IEN, (s != 0) ? 32'h9 : 32'h0);
         apb(1'b1, irrx_pkg::ADDR_CTRL, 32'h1 | (32'(s[1]) << 5) | (32'(s[0]) << 6));
         repeat (10) @(posedge mclk);
         src.send(1'b1, 5 * m);
         src.send(1'b0, 4 * m);
         src.send(1'b1, (15 + $unsigned($random(seed)) % 20) * m);
         src.send(1'b0, 15 * m);
         src.send(1'b1, 6 * m);
         lo = 15;
         hi = 5;
         if (s == 0) lo = 6 + $unsigned($random(seed)) % 4;
         if (s == 1) hi = 3;
         if (s == 2) hi = 9;
         if (s == 3) hi = 70;
         if (s == 4) lo = 40;
         if (s == 5) lo = 60;
         src.send(1'b0, lo * m);
         src.send(1'b1, hi * m);
         if (s < 5) exp_err++;
         src.send(1'b0, 5 * m);
         src.send(1'b1, 5 * m);
         src.send(1'b0, 40 * m);
         chk("error pulses", 32'(exp_err), 32'(pulses));
         apb(1'b0, irrx_pkg::ADDR_STATUS, 32'h0);
         chk("status", exp_status(s), q);
         chk("irq level", (s != 0) ? 32'h1 : 32'h0, {31'h0, irq});
         apb(1'b1, irrx_pkg::ADDR_CLEAR, 32'hF);
         apb(1'b0, irrx_pkg::ADDR_STATUS, 32'h0);
         chk("status cleared", 32'h0, q);
         chk("irq cleared", 32'h0, {31'h0, irq});
         apb(1'b0, irrx_pkg::ADDR_BITCNT, 32'h0);
         chk("bit count", (s == 5) ? 32'h1 : 32'h0, q);
      end
      stop_test();
   end
endmodule
